// ---- pkg/aaf_pkg.sv ----
// Constants, field layouts and types of the accumulate/average filter.
// Assumes one 200 MHz core clock and an 8-bit register port.
package aaf_pkg;

  // ****************************************
  // Register offsets (byte port, 8 bits)
  // ****************************************
  localparam logic [3:0] OFF_ACC_LO  = 4'h0; // Accumulator low byte
  localparam logic [3:0] OFF_ACC_HI  = 4'h1; // Accumulator high byte
  localparam logic [3:0] OFF_COUNT   = 4'h2; // Sample count
  localparam logic [3:0] OFF_REPEAT  = 4'h3; // Repeat setting
  localparam logic [3:0] OFF_CTRL    = 4'h4; // Computation control
  localparam logic [3:0] OFF_STAT    = 4'h5; // Computation status
  localparam logic [3:0] OFF_FLT_LO  = 4'h6; // Filter result low byte
  localparam logic [3:0] OFF_FLT_HI  = 4'h7; // Filter result high byte

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int CTRL_MODE_LSB  = 0; // Mode field bits 2:0
  localparam int CTRL_SHIFT_LSB = 3; // Shift field bits 5:3
  localparam int CTRL_CLR_BIT   = 6; // Accumulator clear bit
  localparam int CTRL_GO_BIT    = 7; // Conversion start bit
  localparam int STAT_OVF_BIT   = 0; // Overflow flag
  localparam int STAT_BUSY_BIT  = 1; // Clear in progress

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  REPEAT_RST = 8'h00;
  localparam logic [15:0] ACC_RST    = 16'h0000;
  localparam logic [7:0]  COUNT_RST  = 8'h00;
  localparam logic [7:0]  COUNT_MAX  = 8'hFF;
  localparam logic [2:0]  CLR_CYCLES = 3'h5; // Converter clocks per clear

  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic [2:0] {
    MODE_BASIC = 3'h0,
    MODE_ACCUM = 3'h1,
    MODE_AVG   = 3'h2
  } aaf_mode_e;

  typedef enum logic [1:0] {
    ST_RUN   = 2'h1,
    ST_CLEAR = 2'h2
  } aaf_state_e;

  // Control register layout
  typedef struct packed {
    logic       go;
    logic       clr;
    logic [2:0] shift;
    logic [2:0] mode;
  } aaf_ctrl_s;

endpackage

// ---- rtl/aaf_filter.sv ----
// Accumulate/average post-processing behind a converter result path.
// Assumes conversion results arrive on the core clock as one-cycle
// strobes, already right-justified, and a simple byte register port.
`timescale 1ns/100ps

module aaf_filter #(
  parameter int RES_W = 10 // Conversion result width
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  // Register port
  input  wire logic [3:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [7:0]       reg_rdata_o,
  // Converter result path
  input  wire logic             res_valid_i,
  input  wire logic [RES_W-1:0] res_data_i,
  output logic                  conv_start_o,
  // Threshold comparison request
  output logic                  cmp_req_o,
  output logic      [15:0]      cmp_value_o
);

  // ****************************************
  // Registers
  // ****************************************
  aaf_pkg::aaf_ctrl_s  ctrl_r;      // Mode, shift, clear, go
  aaf_pkg::aaf_state_e state_r;     // Run or clearing
  logic [15:0]         acc_r;       // Accumulator value
  logic [7:0]          count_r;     // Sample count
  logic [7:0]          repeat_r;    // Repeat setting
  logic [15:0]         flt_r;       // Filter result
  logic                ovf_r;       // Overflow flag
  logic [2:0]          clr_cnt_r;   // Clear cycle counter

  // ****************************************
  // Combinational helpers
  // ****************************************
  logic [16:0] sum_nxt;    // Sum with carry out
  logic        take;       // Sample joins accumulator
  logic        clr_done;   // Last cycle of clearing
  logic        wr_ctrl;    // Write to control register
  aaf_pkg::aaf_ctrl_s wctrl; // Control write data view

  assign wctrl   = aaf_pkg::aaf_ctrl_s'(reg_wdata_i);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == aaf_pkg::OFF_CTRL);

  // Result is taken zero-extended, so the sum stays right-justified
  // whatever format the converter presents elsewhere.
  assign sum_nxt = {1'b0, acc_r}
                 + {{(17-RES_W){1'b0}}, res_data_i};

  // Only the two accumulating modes feed the accumulator; samples
  // landing during a clear are dropped so the clear stays clean.
  assign take = res_valid_i && (state_r == aaf_pkg::ST_RUN)
             && ((ctrl_r.mode == aaf_pkg::MODE_ACCUM)
             ||  (ctrl_r.mode == aaf_pkg::MODE_AVG));

  assign clr_done = (state_r == aaf_pkg::ST_CLEAR)
                 && (clr_cnt_r == aaf_pkg::CLR_CYCLES - 3'h1);

  // ****************************************
  // Clear sequencer
  // ****************************************

  // Clear runs a fixed number of converter cycles before the
  // state is zeroed; the block runs on the converter clock.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_r   <= aaf_pkg::ST_RUN;
      clr_cnt_r <= 3'h0;
    end else begin
      case (state_r)
        aaf_pkg::ST_RUN: begin
          // Software request starts the sequence
          if (wr_ctrl && wctrl.clr) begin
            state_r   <= aaf_pkg::ST_CLEAR;
            clr_cnt_r <= 3'h0;
          end
        end
        aaf_pkg::ST_CLEAR: begin
          // Count the clear cycles
          if (clr_done) begin
            state_r <= aaf_pkg::ST_RUN;
          end else begin
            clr_cnt_r <= clr_cnt_r + 3'h1;
          end
        end
        default: begin
          state_r <= aaf_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // Control register
  // ****************************************

  // Clear bit reads back high until the sequence ends, so
  // software can poll it; go is a self-clearing request.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl_r <= aaf_pkg::aaf_ctrl_s'(aaf_pkg::CTRL_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_r.mode  <= wctrl.mode;
        ctrl_r.shift <= wctrl.shift;
        ctrl_r.go    <= wctrl.go;
        // Writing zero never cancels a running clear, and a clear
        // write landing on the last clear cycle is absorbed rather
        // than leaving the bit stuck high with no sequence behind it
        if (state_r == aaf_pkg::ST_RUN) begin
          ctrl_r.clr <= wctrl.clr;
        end else begin
          ctrl_r.clr <= !clr_done;
        end
      end else begin
        ctrl_r.go <= 1'b0;
        if (clr_done) begin
          ctrl_r.clr <= 1'b0;
        end
      end
    end
  end

  // Start pulse toward the converter core
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= wr_ctrl && wctrl.go;
    end
  end

  // ****************************************
  // Repeat setting
  // ****************************************

  // Number of samples software wants gathered
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      repeat_r <= aaf_pkg::REPEAT_RST;
    end else if (reg_wr_i && (reg_addr_i == aaf_pkg::OFF_REPEAT)) begin
      repeat_r <= reg_wdata_i;
    end
  end

  // ****************************************
  // Accumulator
  // ****************************************

  // Hardware sample wins over a software byte write in the same
  // cycle, so no conversion is ever lost to a register write.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      acc_r <= aaf_pkg::ACC_RST;
    end else if (clr_done) begin
      acc_r <= aaf_pkg::ACC_RST;
    end else if (take) begin
      // Low 16 bits kept; wrap modulo 65536
      acc_r <= sum_nxt[15:0];
    end else if (reg_wr_i && (reg_addr_i == aaf_pkg::OFF_ACC_LO)) begin
      acc_r[7:0] <= reg_wdata_i;
    end else if (reg_wr_i && (reg_addr_i == aaf_pkg::OFF_ACC_HI)) begin
      acc_r[15:8] <= reg_wdata_i;
    end
  end

  // ****************************************
  // Overflow flag
  // ****************************************

  // Sticky; only the clear sequence removes it
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ovf_r <= 1'b0;
    end else if (take && sum_nxt[16]) begin
      ovf_r <= 1'b1;
    end else if (clr_done) begin
      ovf_r <= 1'b0;
    end
  end

  // ****************************************
  // Sample count
  // ****************************************

  // Saturates rather than wrapping so that a long run still
  // compares as at-or-beyond the repeat setting.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      count_r <= aaf_pkg::COUNT_RST;
    end else if (clr_done) begin
      count_r <= aaf_pkg::COUNT_RST;
    end else if (take && (count_r != aaf_pkg::COUNT_MAX)) begin
      count_r <= count_r + 8'h01;
    end
  end

  // ****************************************
  // Filter result
  // ****************************************

  // Shifted copy of the new sum, taken on every accepted sample
  // in either accumulating mode; larger shift settings scale it down more.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      flt_r <= 16'h0000;
    end else if (clr_done) begin
      flt_r <= 16'h0000;
    end else if (take) begin
      flt_r <= sum_nxt[15:0] >> ctrl_r.shift;
    end
  end

  // ****************************************
  // Threshold comparison request
  // ****************************************

  // Decides when the external comparator acts and on what value;
  // the comparison itself lives outside this block.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cmp_req_o   <= 1'b0;
      cmp_value_o <= 16'h0000;
    end else begin
      cmp_req_o <= 1'b0;
      if (res_valid_i && (state_r == aaf_pkg::ST_RUN)) begin
        case (ctrl_r.mode)
          aaf_pkg::MODE_ACCUM: begin
            // Every sample, on the accumulated value
            cmp_req_o   <= 1'b1;
            cmp_value_o <= sum_nxt[15:0];
          end
          aaf_pkg::MODE_AVG: begin
            // Only once enough samples are in, on the average
            if ((count_r + 8'h01 >= repeat_r)
                || (count_r == aaf_pkg::COUNT_MAX)) begin
              cmp_req_o <= 1'b1;
            end
            cmp_value_o <= sum_nxt[15:0] >> ctrl_r.shift;
          end
          default: begin
            // Basic and unused modes compare the raw result
            cmp_req_o   <= 1'b1;
            cmp_value_o <= {{(16-RES_W){1'b0}}, res_data_i};
          end
        endcase
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************

  // Data stand in the cycle after the strobe only; unmapped
  // offsets and idle cycles read as zero.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        aaf_pkg::OFF_ACC_LO: reg_rdata_o <= acc_r[7:0];
        aaf_pkg::OFF_ACC_HI: reg_rdata_o <= acc_r[15:8];
        aaf_pkg::OFF_COUNT:  reg_rdata_o <= count_r;
        aaf_pkg::OFF_REPEAT: reg_rdata_o <= repeat_r;
        aaf_pkg::OFF_CTRL:   reg_rdata_o <= ctrl_r;
        aaf_pkg::OFF_STAT: begin
          reg_rdata_o <= 8'h00;
          reg_rdata_o[aaf_pkg::STAT_OVF_BIT]  <= ovf_r;
          reg_rdata_o[aaf_pkg::STAT_BUSY_BIT] <= (state_r == aaf_pkg::ST_CLEAR);
        end
        aaf_pkg::OFF_FLT_LO: reg_rdata_o <= flt_r[7:0];
        aaf_pkg::OFF_FLT_HI: reg_rdata_o <= flt_r[15:8];
        default:             reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

// ---- testbench/aaf_conv_model.sv ----
// Converter core model: answers a start or a trigger with one result.
// Assumes it runs on the block's core clock.
`timescale 1ns/100ps

module aaf_conv_model #(
  parameter int RES_W = 10, // Result width
  parameter int LAT   = 3   // Cycles from start to result (slow answer)
) (
  // Clock
  input  wire logic             clk_i,
  // Requests
  input  wire logic             start_i,
  input  wire logic             trig_i,
  input  wire logic [RES_W-1:0] data_i,
  // Result path
  output logic                  valid_o,
  output logic      [RES_W-1:0] data_o
);
  // ****
  // Conversion timing
  // ****
  int cnt = 0; // Cycles left of a started conversion

  initial begin
    valid_o = 1'b0;
    data_o  = '0;
  end

  // Start answers after LAT, an external trigger at the next edge
  always @(posedge clk_i) begin
    cnt     <= start_i ? LAT : (cnt > 0 ? cnt - 1 : 0);
    valid_o <= trig_i || cnt == 1;
    // Idle data toggles so a stale value is never mistaken for a result
    data_o  <= (trig_i || cnt == 1) ? data_i : ~data_o;
  end
endmodule

// ---- testbench/aaf_filter_properties.sv ----
// Port-level checks of the filter, bound into every aaf_filter.
// Assumes srst_i synchronous, active high, on core_clk_i.
`timescale 1ns/100ps

module aaf_filter_properties #(
  parameter int RES_W = 10 // Result width
) (
  // Clock and reset
  input wire logic             core_clk_i,
  input wire logic             srst_i,
  // Register port
  input wire logic [3:0]       reg_addr_i,
  input wire logic [7:0]       reg_wdata_i,
  input wire logic             reg_wr_i,
  input wire logic             reg_rd_i,
  input wire logic [7:0]       reg_rdata_o,
  // Result path
  input wire logic             res_valid_i,
  input wire logic [RES_W-1:0] res_data_i,
  input wire logic             conv_start_o,
  input wire logic             cmp_req_o,
  input wire logic [15:0]      cmp_value_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  logic [2:0] mode_r;  // Mode last written
  logic [2:0] clr_r;   // Edges left in a clear window
  logic       ctrl_wr; // Control write this cycle
  assign ctrl_wr = reg_wr_i && reg_addr_i == aaf_pkg::OFF_CTRL;

  // Mode shadow
  always_ff @(posedge core_clk_i) begin
    if (srst_i) mode_r <= 3'h0;
    else if (ctrl_wr) mode_r <= reg_wdata_i[2:0];
  end
  // Clear window; non-zero exactly while the filter is clearing
  always_ff @(posedge core_clk_i) begin
    if (srst_i) clr_r <= 3'h0;
    else if (ctrl_wr && reg_wdata_i[aaf_pkg::CTRL_CLR_BIT] && clr_r == 3'h0) clr_r <= 3'h5;
    else if (clr_r != 3'h0) clr_r <= clr_r - 3'h1;
  end

  // ****
  // Properties
  // ****
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_go; ctrl_wr && reg_wdata_i[aaf_pkg::CTRL_GO_BIT] |=> conv_start_o; endproperty
  a_go: assert property (p_go) else $error("no start pulse");
  property p_start; conv_start_o |-> $past(ctrl_wr && reg_wdata_i[7]); endproperty
  a_start: assert property (p_start) else $error("start without go");
  property p_cmp_cause; cmp_req_o |-> $past(res_valid_i); endproperty
  a_cmp_cause: assert property (p_cmp_cause) else $error("compare without result");
  property p_cmp_hold; !res_valid_i |=> $stable(cmp_value_o); endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("compare value moved");
  property p_basic;
    res_valid_i && clr_r == 3'h0 && !(mode_r inside {3'h1, 3'h2})
      |=> cmp_req_o && cmp_value_o == 16'($past(res_data_i));
  endproperty
  a_basic: assert property (p_basic) else $error("basic compare wrong");
  property p_accum; res_valid_i && clr_r == 3'h0 && mode_r == 3'h1 |=> cmp_req_o; endproperty
  a_accum: assert property (p_accum) else $error("accumulate compare missing");
  property p_drop; res_valid_i && clr_r inside {[3'h1:3'h5]} |=> !cmp_req_o; endproperty
  a_drop: assert property (p_drop) else $error("result taken during clear");
  c_avg: cover property (cmp_req_o && mode_r == 3'h2);
  c_clr: cover property (clr_r == 3'h1);
  c_go: cover property (conv_start_o);
endmodule

bind aaf_filter aaf_filter_properties #(.RES_W(RES_W)) aaf_filter_properties_inst (
  .core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .res_valid_i, .res_data_i, .conv_start_o, .cmp_req_o, .cmp_value_o);

// ---- testbench/tb.sv ----
// Self-checking bench of the accumulate/average filter.
// Assumes the checker binds itself and the converter model feeds results.
`timescale 1ns/100ps

module tb;
  localparam int RES_W = 10; // Result width
  // ****
  // Signals
  // ****
  logic             core_clk_i  = 1'b0;
  logic             srst_i      = 1'b1;
  logic [3:0]       reg_addr_i  = 4'h0;
  logic [7:0]       reg_wdata_i = 8'h00;
  logic             reg_wr_i    = 1'b0;
  logic             reg_rd_i    = 1'b0;
  logic             trig        = 1'b0;    // External trigger to the model
  logic [RES_W-1:0] tdata       = 10'h000; // Next result of the model
  logic [7:0]       reg_rdata_o;
  logic             res_valid_i;
  logic [RES_W-1:0] res_data_i;
  logic             conv_start_o;
  logic             cmp_req_o;
  logic [15:0]      cmp_value_o;
  logic [15:0]      last_val    = 16'h0000; // Last compared value
  int               n_req       = 0;        // Compare requests seen
  int               mismatches  = 0;
  int               n_checks    = 0;
  int               cycles      = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  aaf_filter #(.RES_W(RES_W)) aaf_filter_inst (
    .core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .res_valid_i, .res_data_i, .conv_start_o, .cmp_req_o, .cmp_value_o);
  aaf_conv_model #(.RES_W(RES_W), .LAT(3)) aaf_conv_model_inst (
    .clk_i(core_clk_i), .start_i(conv_start_o), .trig_i(trig), .data_i(tdata),
    .valid_o(res_valid_i), .data_o(res_data_i));

  // Compare request monitor and hang guard
  always @(posedge core_clk_i) begin
    cycles++;
    if (cmp_req_o === 1'b1) begin
      n_req    <= n_req + 1;
      last_val <= cmp_value_o;
    end
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1; reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk({8'h00, reg_rdata_o}, {8'h00, e});
  endtask
  task automatic rd16(input logic [3:0] a, input logic [15:0] e);
    rd(a, e[7:0]);
    rd(a + 4'h1, e[15:8]);
  endtask
  // Hold the trigger n edges: n back-to-back results
  task automatic pulse(input int n, input logic [RES_W-1:0] d);
    @(posedge core_clk_i);
    trig <= 1'b1; tdata <= d;
    repeat (n) @(posedge core_clk_i);
    trig <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    for (int a = 0; a < 9; a++) rd(4'(a), 8'h00);
  endtask
  task automatic t_accum(); // Mode 001, shift 2
    int n0;
    n0 = n_req;
    wr(aaf_pkg::OFF_REPEAT, 8'h04);
    wr(aaf_pkg::OFF_CTRL, 8'h11);
    pulse(3, 10'h3FF);
    rd16(aaf_pkg::OFF_ACC_LO, 16'h0BFD);
    rd(aaf_pkg::OFF_COUNT, 8'h03);
    rd16(aaf_pkg::OFF_FLT_LO, 16'h02FF);
    chk(16'(n_req - n0), 16'h0003);
    chk(last_val, 16'h0BFD);
  endtask
  task automatic t_ovf(); // Wrap past 65535, then saturate the count
    wr(aaf_pkg::OFF_ACC_HI, 8'hFF);
    wr(aaf_pkg::OFF_ACC_LO, 8'hF0);
    pulse(1, 10'h020);
    rd16(aaf_pkg::OFF_ACC_LO, 16'h0010);
    rd(aaf_pkg::OFF_STAT, 8'h01);
    pulse(255, 10'h000);
    rd(aaf_pkg::OFF_STAT, 8'h01);
    rd(aaf_pkg::OFF_COUNT, 8'hFF);
  endtask
  task automatic t_clear(); // Clear into mode 010 shift 1, a result lands inside
    int ones;
    int n0;
    ones = 0;
    n0 = n_req;
    wr(aaf_pkg::OFF_CTRL, 8'h4A);
    reg_rd_i <= 1'b1;
    reg_addr_i <= aaf_pkg::OFF_CTRL;
    for (int i = 1; i <= 8; i++) begin
      @(posedge core_clk_i);
      trig <= (i == 1);
      #1;
      if (reg_rdata_o[6] === 1'b1) ones++;
    end
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    chk(16'(ones), 16'h0005);
    chk(16'(n_req - n0), 16'h0000);
    rd16(aaf_pkg::OFF_ACC_LO, 16'h0000);
    rd(aaf_pkg::OFF_COUNT, 8'h00);
    rd(aaf_pkg::OFF_STAT, 8'h00);
    rd(aaf_pkg::OFF_CTRL, 8'h0A);
  endtask
  task automatic t_avg();
    int n0;
    n0 = n_req;
    wr(aaf_pkg::OFF_REPEAT, 8'h02);
    pulse(1, 10'h100);
    chk(16'(n_req - n0), 16'h0000);
    pulse(1, 10'h101);
    chk(16'(n_req - n0), 16'h0001);
    chk(last_val, 16'h0100);
    rd16(aaf_pkg::OFF_FLT_LO, 16'h0100);
    rd(aaf_pkg::OFF_COUNT, 8'h02);
  endtask
  task automatic t_basic(); // Modes 000 and 011 leave the sum alone
    int n0;
    for (int m = 0; m < 4; m += 3) begin
      n0 = n_req;
      wr(aaf_pkg::OFF_CTRL, 8'(m));
      pulse(1, 10'h2A5);
      chk(16'(n_req - n0), 16'h0001);
      chk(last_val, 16'h02A5);
      rd16(aaf_pkg::OFF_ACC_LO, 16'h0201);
    end
  endtask
  task automatic t_go(); // Software start, slow converter answer
    @(posedge core_clk_i);
    tdata <= 10'h005;
    wr(aaf_pkg::OFF_CTRL, 8'h81);
    repeat (6) @(posedge core_clk_i);
    rd16(aaf_pkg::OFF_ACC_LO, 16'h0206);
    rd16(aaf_pkg::OFF_FLT_LO, 16'h0206);
    rd(aaf_pkg::OFF_CTRL, 8'h01);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_accum();
    t_ovf();
    t_clear();
    t_avg();
    t_basic();
    t_go();
    stop_test();
  end
endmodule
